// *** cnso_pkg.sv ***
// Shared constants for the negate, idle and stack-drop execute block
package cnso_pkg;

  // ------------------------------------------------------------
  // Opcode patterns
  // ------------------------------------------------------------
  localparam logic [6:0] NEG_PATTERN = 7'h36;
  localparam logic [15:0] IDLE_ZERO_WORD = 16'h0000;
  localparam logic [3:0] IDLE_TOP_NIBBLE = 4'hf;
  localparam logic [15:0] STACK_DROP_WORD = 16'h0006;
  localparam int BANK_BIT = 8;

  // ------------------------------------------------------------
  // Data addressing
  // ------------------------------------------------------------
  localparam int DADDR_W = 12;
  localparam int BANK_W = 4;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // ------------------------------------------------------------
  // Return stack
  // ------------------------------------------------------------
  localparam int STACK_W = 21;
  localparam int STACK_DEPTH = 31;
  localparam int SP_W = 5;

  // ------------------------------------------------------------
  // Register map, byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BANK = 8'h04;
  localparam logic [7:0] REG_INDEX_BASE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_STACK_PTR = 8'h10;
  localparam logic [7:0] REG_STACK_TOP = 8'h14;
  localparam logic [7:0] REG_STACK_PUSH = 8'h18;
  localparam logic [7:0] REG_RETIRED = 8'h1c;

  // ------------------------------------------------------------
  // Status and control field positions
  // ------------------------------------------------------------
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_OVF = 3;
  localparam int ST_NEG = 4;
  localparam int ST_UNDERFLOW = 6;
  localparam int ST_OVERFLOW = 7;
  localparam int CTRL_EXT = 0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : cnso_pkg

// *** cnso_negate.sv ***
// Two's complement negation with arithmetic flag generation
`timescale 1ns/100ps
module cnso_negate (
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic [4:0] flags
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // ------------------------------------------------------------
  // Invert and add one
  // ------------------------------------------------------------
  always_comb begin
    full_sum = {1'b0, ~operand} + 9'h001;
    low_sum = {1'b0, ~operand[3:0]} + 5'h01;
    result = full_sum[7:0];
    flags = '0;
    flags[cnso_pkg::ST_CARRY] = full_sum[8];
    flags[cnso_pkg::ST_DIGIT] = low_sum[4];
    flags[cnso_pkg::ST_ZERO] = (full_sum[7:0] == 8'h00);
    flags[cnso_pkg::ST_OVF] = (operand == 8'h80);
    flags[cnso_pkg::ST_NEG] = full_sum[7];
  end

endmodule : cnso_negate

// *** cnso_core.sv ***
// Execute logic for negate, idle and return-stack drop, with AXI4-Lite registers
`timescale 1ns/100ps
module cnso_core #(
  parameter int DEPTH = cnso_pkg::STACK_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic retire,
  output logic [cnso_pkg::DADDR_W-1:0] dmem_addr,
  output logic dmem_rd_en,
  input wire logic [7:0] dmem_rdata,
  output logic dmem_wr_en,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} cnso_phase_e;
  typedef enum logic [1:0] {OP_NONE, OP_NEG, OP_DROP} cnso_op_e;

  typedef struct packed {
    cnso_phase_e phase;
    cnso_op_e op;
    logic [15:0] word;
    logic [7:0] operand;
    logic instr_ready;
    logic retire;
    logic [cnso_pkg::DADDR_W-1:0] dmem_addr;
    logic dmem_rd_en;
    logic dmem_wr_en;
    logic [7:0] dmem_wdata;
    logic ext_en;
    logic [cnso_pkg::BANK_W-1:0] bank_select_register;
    logic [cnso_pkg::DADDR_W-1:0] index_base;
    logic [7:0] status;
    logic [cnso_pkg::SP_W-1:0] sp;
    logic [DEPTH-1:0][cnso_pkg::STACK_W-1:0] stack;
    logic [15:0] retired;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cnso_state_s;

  cnso_state_s cur;
  cnso_state_s next_cur;
  logic [7:0] neg_result;
  logic [4:0] neg_flags;
  localparam logic [cnso_pkg::SP_W-1:0] SP_FULL = cnso_pkg::SP_W'(DEPTH);

  cnso_negate u_negate (
    .operand(cur.operand),
    .result(neg_result),
    .flags(neg_flags)
  );

  // ------------------------------------------------------------
  // Operand address forming
  // ------------------------------------------------------------
  function automatic logic [cnso_pkg::DADDR_W-1:0] form_addr(
    input logic [15:0] word,
    input logic ext_en,
    input logic [cnso_pkg::BANK_W-1:0] bank,
    input logic [cnso_pkg::DADDR_W-1:0] base
  );
    logic [7:0] f;
    logic [cnso_pkg::DADDR_W-1:0] a;
    f = word[7:0];
    if (word[cnso_pkg::BANK_BIT]) begin
      a = {bank, f};
    end else if (ext_en && (f <= cnso_pkg::INDEXED_LIMIT)) begin
      a = base + {{(cnso_pkg::DADDR_W-8){1'b0}}, f};
    end else if (f < cnso_pkg::ACCESS_SPLIT) begin
      a = {cnso_pkg::ACCESS_LOW_BANK, f};
    end else begin
      a = {cnso_pkg::ACCESS_HIGH_BANK, f};
    end
    return a;
  endfunction : form_addr

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] waddr;
    logic [31:0] wd;
    logic [7:0] raddr;
    logic do_write;
    logic [cnso_pkg::SP_W-1:0] top_idx;
    waddr = cur.aw_addr;
    wd = cur.w_data;
    raddr = s_axi_araddr;
    do_write = 1'b0;
    top_idx = (cur.sp == '0) ? '0 : cur.sp - 1'b1;
    next_cur = cur;
    next_cur.retire = 1'b0;
    next_cur.dmem_rd_en = 1'b0;
    next_cur.dmem_wr_en = 1'b0;

    // Instruction phases
    case (cur.phase)
      PH_IDLE: begin
        if (instr_valid && cur.instr_ready) begin
          next_cur.word = instr_word;
          next_cur.instr_ready = 1'b0;
          next_cur.phase = PH_Q1;
        end
      end
      PH_Q1: begin
        if (cur.word[15:9] == cnso_pkg::NEG_PATTERN) begin
          next_cur.op = OP_NEG;
          next_cur.dmem_addr = form_addr(cur.word, cur.ext_en, cur.bank_select_register, cur.index_base);
          next_cur.dmem_rd_en = 1'b1;
        end else if (cur.word == cnso_pkg::STACK_DROP_WORD) begin
          next_cur.op = OP_DROP;
        end else begin
          next_cur.op = OP_NONE;
        end
        next_cur.phase = PH_Q2;
      end
      PH_Q2: begin
        if (cur.op == OP_NEG) begin
          next_cur.operand = dmem_rdata;
        end
        next_cur.phase = PH_Q3;
      end
      PH_Q3: begin
        if (cur.op == OP_NEG) begin
          next_cur.dmem_wdata = neg_result;
          next_cur.dmem_wr_en = 1'b1;
          next_cur.status[cnso_pkg::ST_NEG:cnso_pkg::ST_CARRY] = neg_flags;
        end
        if (cur.op == OP_DROP) begin
          if (cur.sp == '0) begin
            next_cur.status[cnso_pkg::ST_UNDERFLOW] = 1'b1;
          end else begin
            next_cur.sp = cur.sp - 1'b1;
          end
        end
        next_cur.phase = PH_Q4;
      end
      PH_Q4: begin
        next_cur.retire = 1'b1;
        next_cur.retired = cur.retired + 16'h0001;
        next_cur.instr_ready = 1'b1;
        next_cur.op = OP_NONE;
        next_cur.phase = PH_IDLE;
      end
      default: begin
        next_cur.phase = PH_IDLE;
        next_cur.instr_ready = 1'b1;
      end
    endcase

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    if (s_axi_awvalid && cur.awready) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
      next_cur.awready = 1'b0;
      waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur.wready) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_strb = s_axi_wstrb;
      next_cur.wready = 1'b0;
      wd = s_axi_wdata;
    end
    if (next_cur.aw_held && next_cur.w_held && !cur.bvalid) begin
      do_write = next_cur.w_strb[0];
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = cnso_pkg::RESP_OKAY;
      case (waddr)
        cnso_pkg::REG_CTRL: begin
          if (do_write) begin
            next_cur.ext_en = wd[cnso_pkg::CTRL_EXT];
          end
        end
        cnso_pkg::REG_BANK: begin
          if (do_write) begin
            next_cur.bank_select_register = wd[cnso_pkg::BANK_W-1:0];
          end
        end
        cnso_pkg::REG_INDEX_BASE: begin
          if (do_write) begin
            next_cur.index_base[7:0] = wd[7:0];
          end
          if (next_cur.w_strb[1]) begin
            next_cur.index_base[cnso_pkg::DADDR_W-1:8] = wd[cnso_pkg::DADDR_W-1:8];
          end
        end
        cnso_pkg::REG_STATUS: begin
          // Sticky bits clear on one; a new event in the same cycle wins
          if (do_write && wd[cnso_pkg::ST_UNDERFLOW] && !(cur.phase == PH_Q3 && cur.op == OP_DROP &&
              cur.sp == '0)) begin
            next_cur.status[cnso_pkg::ST_UNDERFLOW] = 1'b0;
          end
          if (do_write && wd[cnso_pkg::ST_OVERFLOW]) begin
            next_cur.status[cnso_pkg::ST_OVERFLOW] = 1'b0;
          end
        end
        cnso_pkg::REG_STACK_PUSH: begin
          // Test load of the stack, refused while an instruction runs
          if (cur.phase != PH_IDLE || !(&next_cur.w_strb[2:0])) begin
            next_cur.bresp = cnso_pkg::RESP_SLVERR;
          end else if (cur.sp == SP_FULL) begin
            next_cur.status[cnso_pkg::ST_OVERFLOW] = 1'b1;
          end else begin
            next_cur.stack[cur.sp] = wd[cnso_pkg::STACK_W-1:0];
            next_cur.sp = cur.sp + 1'b1;
          end
        end
        cnso_pkg::REG_STACK_PTR, cnso_pkg::REG_STACK_TOP, cnso_pkg::REG_RETIRED: begin
          next_cur.bresp = cnso_pkg::RESP_OKAY;
        end
        default: begin
          next_cur.bresp = cnso_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
      next_cur.awready = 1'b1;
      next_cur.wready = 1'b1;
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    if (s_axi_arvalid && cur.arready) begin
      next_cur.arready = 1'b0;
      next_cur.rvalid = 1'b1;
      next_cur.rresp = cnso_pkg::RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      case (raddr)
        cnso_pkg::REG_CTRL: begin
          next_cur.rdata[cnso_pkg::CTRL_EXT] = cur.ext_en;
        end
        cnso_pkg::REG_BANK: begin
          next_cur.rdata[cnso_pkg::BANK_W-1:0] = cur.bank_select_register;
        end
        cnso_pkg::REG_INDEX_BASE: begin
          next_cur.rdata[cnso_pkg::DADDR_W-1:0] = cur.index_base;
        end
        cnso_pkg::REG_STATUS: begin
          next_cur.rdata[7:0] = cur.status;
        end
        cnso_pkg::REG_STACK_PTR: begin
          next_cur.rdata[cnso_pkg::SP_W-1:0] = cur.sp;
        end
        cnso_pkg::REG_STACK_TOP: begin
          if (cur.sp != '0) begin
            next_cur.rdata[cnso_pkg::STACK_W-1:0] = cur.stack[top_idx];
          end
        end
        cnso_pkg::REG_RETIRED: begin
          next_cur.rdata[15:0] = cur.retired;
        end
        cnso_pkg::REG_STACK_PUSH: begin
          next_cur.rdata = 32'h0000_0000;
        end
        default: begin
          next_cur.rresp = cnso_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
      next_cur.arready = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cur <= '0;
      cur.phase <= PH_IDLE;
      cur.op <= OP_NONE;
      cur.instr_ready <= 1'b1;
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.arready <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign instr_ready = cur.instr_ready;
  assign retire = cur.retire;
  assign dmem_addr = cur.dmem_addr;
  assign dmem_rd_en = cur.dmem_rd_en;
  assign dmem_wr_en = cur.dmem_wr_en;
  assign dmem_wdata = cur.dmem_wdata;
  assign s_axi_awready = cur.awready;
  assign s_axi_wready = cur.wready;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_arready = cur.arready;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign s_axi_rvalid = cur.rvalid;

endmodule : cnso_core

// *** cnso_chk_assertions.sv ***
// Protocol checker for the negate, idle and stack-drop core
`timescale 1ns/100ps
module cnso_chk #(
  parameter int DEPTH = 31
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic retire,
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_rd_en,
  input wire logic [7:0] dmem_rdata,
  input wire logic dmem_wr_en,
  input wire logic [7:0] dmem_wdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----
  // Steps of one instruction
  // ----
  sequence s_take;
    instr_valid && instr_ready;
  endsequence
  sequence s_neg;
    s_take ##0 instr_word[15:9] == cnso_pkg::NEG_PATTERN;
  endsequence
  sequence s_busy;
    !instr_ready [*4] ##1 instr_ready;
  endsequence
  a_busy_window: assert property (s_take |=> s_busy)
    else $error("ready window wrong");
  a_retire_five: assert property (s_take |-> ##5 retire)
    else $error("retire missing");
  a_retire_cause: assert property (retire |-> $past(instr_valid && instr_ready, 5))
    else $error("retire without take");
  a_neg_read: assert property (s_neg |-> ##2 dmem_rd_en && !dmem_wr_en)
    else $error("negate read missing");
  a_neg_value: assert property (dmem_wr_en |-> dmem_wdata == 8'(~$past(dmem_rdata) + 8'h01))
    else $error("negate value wrong");
  a_same_byte: assert property (dmem_wr_en |-> $past(dmem_rd_en, 2) && dmem_addr == $past(dmem_addr, 2))
    else $error("write address wrong");
  a_other_quiet: assert property (s_take ##0 instr_word[15:9] != cnso_pkg::NEG_PATTERN
    |=> (!dmem_rd_en && !dmem_wr_en) [*5])
    else $error("data access by non-negate");
  a_bank_low: assert property (s_neg ##0 instr_word[8] |-> ##2 dmem_addr[7:0] == $past(instr_word[7:0], 2))
    else $error("banked address wrong");
  a_access_high: assert property (s_neg ##0 !instr_word[8] && instr_word[7:0] >= cnso_pkg::ACCESS_SPLIT
    |-> ##2 dmem_addr == {cnso_pkg::ACCESS_HIGH_BANK, $past(instr_word[7:0], 2)})
    else $error("access bank address wrong");
endmodule : cnso_chk

bind cnso_core cnso_chk #(.DEPTH(DEPTH)) u_chk (
  .clk(clk),
  .rstn(rstn),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .instr_ready(instr_ready),
  .retire(retire),
  .dmem_addr(dmem_addr),
  .dmem_rd_en(dmem_rd_en),
  .dmem_rdata(dmem_rdata),
  .dmem_wr_en(dmem_wr_en),
  .dmem_wdata(dmem_wdata)
);

// *** cnso_dmem.sv ***
// Behavioural data memory facing the core
`timescale 1ns/100ps
module cnso_dmem (
  input wire logic clk,
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_rd_en,
  input wire logic dmem_wr_en,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] junk = 8'h5a;
  logic rd_q = 1'h0;
  always @(posedge clk) begin
    rd_q <= dmem_rd_en;
    junk <= junk + 8'h3b;
    if (dmem_wr_en) begin
      mem[dmem_addr] <= dmem_wdata;
    end
  end
  // Data only valid around a read, changing garbage otherwise
  assign dmem_rdata = (dmem_rd_en || rd_q) ? mem[dmem_addr] : junk;
endmodule : cnso_dmem

// *** testbench.sv ***
// Self-checking bench for the negate, idle and stack-drop core
`timescale 1ns/100ps
module testbench;
  logic clk = 1'h0, rstn = 1'h0, iv = 1'h0, ir, ret, rde, wre;
  logic [15:0] iw = 16'h0;
  logic [11:0] da, wa;
  logic [7:0] rdd, wdd, awa = 8'h0, ara = 8'h0;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, awr, wr_, bv, arr, rv;
  logic [31:0] wd = 32'h0, rdat;
  logic [3:0] ws = 4'hf;
  logic [1:0] bre, rre;
  int mismatches = 0, checks = 0, nret = 0;
  logic [15:0] nw [6] = '{16'h6c3a, 16'h6c80, 16'h6d00, 16'h6c5f, 16'h6c60, 16'h6dff};
  logic [11:0] na [6] = '{12'h03a, 12'hf80, 12'h500, 12'h25f, 12'hf60, 12'h5ff};
  logic [7:0] nx [6] = '{8'h3a, 8'h80, 8'h00, 8'h01, 8'hff, 8'h7f};
  logic [15:0] idw [4] = '{16'h0000, 16'hf000, 16'hffff, 16'hf6c3};
  always #10 clk = ~clk;
  cnso_core DUT (.clk(clk), .rstn(rstn), .instr_valid(iv), .instr_word(iw), .instr_ready(ir), .retire(ret),
    .dmem_addr(da), .dmem_rd_en(rde), .dmem_rdata(rdd), .dmem_wr_en(wre), .dmem_wdata(wdd),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rre),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  cnso_dmem u_mem (.clk(clk), .dmem_addr(da), .dmem_rd_en(rde), .dmem_wr_en(wre), .dmem_wdata(wdd),
    .dmem_rdata(rdd));
  always @(posedge clk) begin
    if (wre === 1'h1) begin
      wa <= da;
    end
  end
  // ----
  // Compare and finish
  // ----
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 50) begin
      chk("handshake", 32'h0, 32'h1);
      end_sim();
    end
  endtask : hang
  // ----
  // Bus and instruction drivers
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'h1;
    w = 1'h1;
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (!aw && !w && bv === 1'h1) break;
      if (aw && awr === 1'h1) begin
        aw = 1'h0;
        awv <= 1'h0;
      end
      if (w && wr_ === 1'h1) begin
        w = 1'h0;
        wv <= 1'h0;
      end
    end
    hang(n);
    br <= 1'h0;
    chk("bresp", {30'h0, bre}, {30'h0, er});
    @(posedge clk);
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic ar;
    n = 0;
    ar = 1'h1;
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (!ar && rv === 1'h1) break;
      if (ar && arr === 1'h1) begin
        ar = 1'h0;
        arv <= 1'h0;
      end
    end
    hang(n);
    rr <= 1'h0;
    chk(nm, rdat, e);
    chk("rresp", {30'h0, rre}, {30'h0, er});
    @(posedge clk);
  endtask : rc
  task automatic ex(input logic [15:0] word);
    int n;
    n = 0;
    iw <= word;
    iv <= 1'h1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (ir === 1'h1) break;
    end
    hang(n);
    iv <= 1'h0;
    n = 0;
    while (n < 50 && ret !== 1'h1) begin
      @(posedge clk);
      n++;
    end
    hang(n);
    chk("retire delay", n, 5);
    nret++;
  endtask : ex
  function automatic logic [31:0] flg(input logic [7:0] x);
    logic [7:0] r;
    r = ~x + 8'h01;
    flg = {27'h0, r[7], x == 8'h80, r == 8'h00, x[3:0] == 4'h0, x == 8'h00};
  endfunction : flg
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rc("status", cnso_pkg::REG_STATUS, 32'h0, cnso_pkg::RESP_OKAY);
    rc("depth", cnso_pkg::REG_STACK_PTR, 32'h0, cnso_pkg::RESP_OKAY);
    rc("unmapped", 8'h20, 32'h0, cnso_pkg::RESP_SLVERR);
    wr(8'h24, 32'h1, 4'hf, cnso_pkg::RESP_SLVERR);
    wr(cnso_pkg::REG_BANK, 32'h5, 4'hf, cnso_pkg::RESP_OKAY);
    wr(cnso_pkg::REG_INDEX_BASE, 32'h200, 4'hf, cnso_pkg::RESP_OKAY);
    foreach (nw[i]) begin
      wr(cnso_pkg::REG_CTRL, {31'h0, i > 2}, 4'hf, cnso_pkg::RESP_OKAY);
      u_mem.mem[na[i]] = nx[i];
      ex(nw[i]);
      chk("write addr", {20'h0, wa}, {20'h0, na[i]});
      chk("negated", {24'h0, u_mem.mem[na[i]]}, {24'h0, 8'(~nx[i] + 8'h01)});
      rc("flags", cnso_pkg::REG_STATUS, flg(nx[i]), cnso_pkg::RESP_OKAY);
    end
    foreach (idw[i]) ex(idw[i]);
    rc("idle flags", cnso_pkg::REG_STATUS, 32'h10, cnso_pkg::RESP_OKAY);
    chk("idle byte", {24'h0, u_mem.mem[12'h5ff]}, 32'h81);
    wr(cnso_pkg::REG_STACK_PUSH, 32'h0a1b2c, 4'hf, cnso_pkg::RESP_OKAY);
    wr(cnso_pkg::REG_STACK_PUSH, 32'h1f0e0d, 4'hf, cnso_pkg::RESP_OKAY);
    wr(cnso_pkg::REG_STACK_PUSH, 32'h1, 4'h1, cnso_pkg::RESP_SLVERR);
    rc("depth", cnso_pkg::REG_STACK_PTR, 32'h2, cnso_pkg::RESP_OKAY);
    ex(cnso_pkg::STACK_DROP_WORD);
    rc("depth", cnso_pkg::REG_STACK_PTR, 32'h1, cnso_pkg::RESP_OKAY);
    rc("top", cnso_pkg::REG_STACK_TOP, 32'h0a1b2c, cnso_pkg::RESP_OKAY);
    ex(cnso_pkg::STACK_DROP_WORD);
    rc("top", cnso_pkg::REG_STACK_TOP, 32'h0, cnso_pkg::RESP_OKAY);
    rc("drop flags", cnso_pkg::REG_STATUS, 32'h10, cnso_pkg::RESP_OKAY);
    ex(cnso_pkg::STACK_DROP_WORD);
    rc("depth", cnso_pkg::REG_STACK_PTR, 32'h0, cnso_pkg::RESP_OKAY);
    rc("underflow", cnso_pkg::REG_STATUS, 32'h50, cnso_pkg::RESP_OKAY);
    wr(cnso_pkg::REG_STATUS, 32'h40, 4'hf, cnso_pkg::RESP_OKAY);
    rc("cleared", cnso_pkg::REG_STATUS, 32'h10, cnso_pkg::RESP_OKAY);
    // Fill the stack; one load too many sets the overflow bit
    for (int k = 0; k < 31; k++) begin
      wr(cnso_pkg::REG_STACK_PUSH, k, 4'hf, cnso_pkg::RESP_OKAY);
    end
    wr(cnso_pkg::REG_STACK_PUSH, 32'h1f, 4'hf, cnso_pkg::RESP_OKAY);
    rc("full depth", cnso_pkg::REG_STACK_PTR, 32'h1f, cnso_pkg::RESP_OKAY);
    rc("overflow", cnso_pkg::REG_STATUS, 32'h90, cnso_pkg::RESP_OKAY);
    rc("full top", cnso_pkg::REG_STACK_TOP, 32'h1e, cnso_pkg::RESP_OKAY);
    ex(cnso_pkg::STACK_DROP_WORD);
    rc("deep top", cnso_pkg::REG_STACK_TOP, 32'h1d, cnso_pkg::RESP_OKAY);
    // Stack load refused while an instruction runs
    fork
      ex(cnso_pkg::IDLE_ZERO_WORD);
      begin
        repeat (2) @(posedge clk);
        wr(cnso_pkg::REG_STACK_PUSH, 32'h3, 4'hf, cnso_pkg::RESP_SLVERR);
      end
    join
    rc("deep depth", cnso_pkg::REG_STACK_PTR, 32'h1e, cnso_pkg::RESP_OKAY);
    wr(cnso_pkg::REG_STATUS, 32'h80, 4'hf, cnso_pkg::RESP_OKAY);
    rc("ovf cleared", cnso_pkg::REG_STATUS, 32'h10, cnso_pkg::RESP_OKAY);
    rc("retired", cnso_pkg::REG_RETIRED, nret, cnso_pkg::RESP_OKAY);
    end_sim();
  end
endmodule : testbench
